// *** dmatr_bus_model.sv ***
`timescale 1ns/10ps
module dmatr_bus_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic xfer_valid,
  input wire logic [1:0] wait_cyc,
  input wire logic inject_err,
  output logic xfer_ready,
  output logic xfer_done,
  output logic xfer_err
);
  logic [1:0] cnt_reg;
  logic busy_reg;

  // Takes a command wait_cyc+2 cycles after xfer_valid rises, ends it three cycles later
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      xfer_ready <= 1'h0;
      xfer_done <= 1'h0;
      xfer_err <= 1'h0;
      cnt_reg <= 2'h0;
      busy_reg <= 1'h0;
    end
    else
    begin
      xfer_done <= 1'h0;
      xfer_err <= 1'h0;
      if (busy_reg)
      begin
        if (cnt_reg == 2'h0)
        begin
          busy_reg <= 1'h0;
          xfer_done <= !inject_err;
          xfer_err <= inject_err;
        end
        else
          cnt_reg <= cnt_reg - 2'h1;
      end
      else if (xfer_ready)
      begin
        xfer_ready <= 1'h0;
        busy_reg <= 1'h1;
        cnt_reg <= 2'h2;
      end
      else if (xfer_valid)
      begin
        if (cnt_reg == wait_cyc)
          xfer_ready <= 1'h1;
        else
          cnt_reg <= cnt_reg + 2'h1;
      end
    end
  end
endmodule : dmatr_bus_model

// *** dmatr_ctrl.sv ***
`timescale 1ns/10ps
module dmatr_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [dmatr_pkg::NUM_REQ-1:0] dma_req_line,
  input wire logic [dmatr_pkg::NUM_CH-1:0] ch_start,
  input wire logic [dmatr_pkg::NUM_CH-1:0][1:0] ch_xtype,
  input wire logic [dmatr_pkg::NUM_CH-1:0][2:0] ch_bsize,
  input wire logic [dmatr_pkg::NUM_CH-1:0][dmatr_pkg::CNT_W-1:0] ch_count,
  input wire logic [dmatr_pkg::NUM_CH-1:0][3:0] ch_src_line,
  input wire logic [dmatr_pkg::NUM_CH-1:0][3:0] ch_dst_line,
  input wire logic [dmatr_pkg::NUM_CH-1:0] ch_p2p_ok,
  input wire logic [dmatr_pkg::NUM_CH-1:0] soft_burst_req,
  input wire logic [dmatr_pkg::NUM_CH-1:0] soft_single_req,
  output logic xfer_valid,
  output logic xfer_ch,
  output logic [dmatr_pkg::BEAT_W-1:0] xfer_beats,
  input wire logic xfer_ready,
  input wire logic xfer_done,
  input wire logic xfer_err,
  output logic [dmatr_pkg::NUM_CH-1:0] ch_active,
  output logic [dmatr_pkg::NUM_CH-1:0] xfer_complete_irq,
  output logic [dmatr_pkg::NUM_CH-1:0] xfer_error_irq
);
  import dmatr_pkg::*;

  dmatr_req_if req_if ();
  dmatr_state_t state_reg;
  dmatr_state_t state_next;
  logic [NUM_CH-1:0] rdy;
  logic [NUM_CH-1:0] big;
  logic [NUM_CH-1:0] bq;
  logic [NUM_CH-1:0][BEAT_W-1:0] blen;
  logic [NUM_CH-1:0][BEAT_W-1:0] gbeats;
  logic [CNT_W-1:0] rem_left;

  dmatr_req_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .req_line(dma_req_line),
    .req(req_if.src)
  );

  always_comb
  begin
    state_next = state_reg;
    state_next.tc = '0;
    state_next.er = '0;
    rem_left = CNT_ZERO;
    for (int c = 0; c < NUM_CH; c++)
    begin
      blen[c] = dmatr_burst_len(ch_bsize[c]);
      big[c] = state_reg.rem[c] >= CNT_W'(blen[c]);
      unique case (ch_xtype[c])
        XT_M2P: bq[c] = req_if.burst_req[ch_dst_line[c]] | state_reg.sb[c];
        XT_P2M: bq[c] = req_if.burst_req[ch_src_line[c]] | state_reg.sb[c];
        XT_P2P: bq[c] = (req_if.burst_req[ch_src_line[c]] & req_if.burst_req[ch_dst_line[c]])
                        | state_reg.sb[c];
        XT_M2M: bq[c] = 1'b1;
      endcase
      if (ch_xtype[c] == XT_M2M)
      begin
        rdy[c] = 1'b1;
        gbeats[c] = big[c] ? blen[c] : BEAT_W'(state_reg.rem[c]);
      end
      else if (big[c])
      begin
        rdy[c] = bq[c];
        gbeats[c] = blen[c];
      end
      else
      begin
        rdy[c] = bq[c] | state_reg.ss[c];
        gbeats[c] = bq[c] ? BEAT_W'(state_reg.rem[c]) : BEATS_ONE;
      end
      rdy[c] = rdy[c] & state_reg.act[c];
      // Software requests are sticky; a new one in the clearing cycle survives
      state_next.sb[c] = state_reg.sb[c] | soft_burst_req[c];
      state_next.ss[c] = state_reg.ss[c] | soft_single_req[c];
      if (ch_start[c] && !state_reg.act[c])
      begin
        if (ch_xtype[c] == XT_P2P && !ch_p2p_ok[c])
          state_next.er[c] = 1'b1;
        else
        begin
          state_next.act[c] = ch_count[c] != CNT_ZERO;
          state_next.rem[c] = ch_count[c];
          state_next.sb[c] = soft_burst_req[c];
          state_next.ss[c] = soft_single_req[c];
        end
      end
    end
    unique case (state_reg.eng)
      ENG_IDLE:
      begin
        if (rdy[0] || rdy[1])
        begin
          state_next.own = !rdy[0];
          state_next.beats = rdy[0] ? gbeats[0] : gbeats[1];
          state_next.eng = ENG_REQ;
          state_next.sb[!rdy[0]] = soft_burst_req[!rdy[0]];
          state_next.ss[!rdy[0]] = soft_single_req[!rdy[0]];
        end
      end
      ENG_REQ:
      begin
        if (xfer_ready)
          state_next.eng = ENG_RUN;
      end
      ENG_RUN:
      begin
        rem_left = state_reg.rem[state_reg.own] - CNT_W'(state_reg.beats);
        if (xfer_err)
        begin
          state_next.er[state_reg.own] = 1'b1;
          state_next.act[state_reg.own] = 1'b0;
          state_next.eng = ENG_IDLE;
        end
        else if (xfer_done)
        begin
          state_next.rem[state_reg.own] = rem_left;
          if (rem_left == CNT_ZERO)
          begin
            state_next.act[state_reg.own] = 1'b0;
            state_next.tc[state_reg.own] = 1'b1;
          end
          // Returning to idle between bursts lets channel 0 cut in
          state_next.eng = ENG_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= STATE_RESET;
    else
      state_reg <= state_next;
  end

  assign xfer_valid = state_reg.eng == ENG_REQ;
  assign xfer_ch = state_reg.own;
  assign xfer_beats = state_reg.beats;
  assign ch_active = state_reg.act;
  assign xfer_complete_irq = state_reg.tc;
  assign xfer_error_irq = state_reg.er;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_grant;
    state_reg.eng == ENG_IDLE && (rdy[0] || rdy[1]);
  endsequence
  sequence s_hi_run;
    state_reg.eng == ENG_RUN && !state_reg.own;
  endsequence
  sequence s_last_done;
    state_reg.eng == ENG_RUN && xfer_done && !xfer_err
      && state_reg.rem[state_reg.own] == CNT_W'(state_reg.beats);
  endsequence

  AST_BURST_ONLY: assert property (s_grant and (rdy[0] && ch_xtype[0] != XT_M2P
      && ch_xtype[0] != XT_M2M && big[0]) |=> xfer_beats == $past(blen[0]) && xfer_valid)
    else $error("burst-sized remainder did not give a full burst");
  AST_SINGLE_BEAT: assert property (s_grant and (rdy[0] && ch_xtype[0] != XT_M2M
      && !big[0] && !bq[0]) |=> xfer_beats == BEATS_ONE)
    else $error("single request did not give one beat");
  AST_PRIORITY: assert property (s_grant and rdy[0] |=> xfer_valid && !xfer_ch)
    else $error("channel 0 lost arbitration");
  AST_LOW_BLOCKED: assert property (s_hi_run |=> !(xfer_valid && xfer_ch))
    else $error("channel 1 started while channel 0 ran");
  AST_M2M_SELF: assert property (state_reg.eng == ENG_IDLE && ch_active[0]
      && ch_xtype[0] == XT_M2M |=> xfer_valid && !xfer_ch)
    else $error("memory-to-memory channel did not start by itself");
  AST_COMPLETE: assert property (s_last_done |=>
      xfer_complete_irq[$past(state_reg.own)] && !ch_active[$past(state_reg.own)]
      ##1 xfer_complete_irq == '0)
    else $error("completion pulse or channel stop missing");
  AST_ERROR: assert property (state_reg.eng == ENG_RUN && xfer_err |=>
      xfer_error_irq != '0 && !xfer_valid ##1 xfer_error_irq == '0)
    else $error("bus error pulse missing");
  AST_P2P_REJECT: assert property (ch_start[0] && !ch_active[0] && ch_xtype[0] == XT_P2P
      && !ch_p2p_ok[0] |=> xfer_error_irq[0] && !ch_active[0])
    else $error("unsupported peripheral pair was accepted");
  AST_P2P_REJECT1: assert property (ch_start[1] && !ch_active[1] && ch_xtype[1] == XT_P2P
      && !ch_p2p_ok[1] |=> xfer_error_irq[1] && !ch_active[1])
    else $error("unsupported peripheral pair was accepted on channel 1");
  AST_SOFT_START: assert property (soft_burst_req[0] && ch_active[0] && ch_xtype[0] != XT_M2M
      && state_reg.eng == ENG_IDLE && !rdy[1] && !ch_start[0] |-> ##[1:2] xfer_valid)
    else $error("software burst request did not start a transfer");

  // Channel 0 on a peripheral sink waits for its destination line
  sequence s_m2p_quiet;
    state_reg.eng == ENG_IDLE && state_reg.act[0] && ch_xtype[0] == XT_M2P && big[0]
      && !req_if.burst_req[ch_dst_line[0]] && !state_reg.sb[0];
  endsequence

  AST_M2P_PACED: assert property (s_m2p_quiet |=> !(xfer_valid && !xfer_ch))
    else $error("memory-to-peripheral channel ran without its destination request");
  AST_TAIL_BURST: assert property (s_grant and (rdy[0] && ch_xtype[0] == XT_P2M
      && !big[0] && bq[0]) |=> xfer_beats == BEAT_W'($past(state_reg.rem[0])))
    else $error("burst request on a short tail did not move the remainder");
  AST_P2P_PAIR: assert property (s_grant and (rdy[1] && ch_xtype[1] == XT_P2P
      && !state_reg.sb[1] && !state_reg.ss[1]) |-> req_if.burst_req[ch_src_line[1]]
      && req_if.burst_req[ch_dst_line[1]])
    else $error("peripheral pair granted without both burst requests");

  // A pending command must not change under the bus engine
  AST_VALID_HOLD: assert property (xfer_valid && !xfer_ready |=> xfer_valid
      && $stable(xfer_ch) && $stable(xfer_beats))
    else $error("command changed before it was accepted");
  AST_TC_ONE_CYCLE: assert property (xfer_complete_irq != '0
      |=> xfer_complete_irq == '0)
    else $error("completion pulse lasted more than one cycle");

  // Channel 0 takes the next slot even while channel 1 still has work
  AST_CUT_IN: assert property (state_reg.eng == ENG_IDLE && rdy[0] && state_reg.act[1]
      |=> xfer_valid && !xfer_ch)
    else $error("channel 0 could not cut in while channel 1 was active");
endmodule : dmatr_ctrl

// *** dmatr_pkg.sv ***
// Functional notes
// - A memory-to-peripheral channel is paced by its destination's burst request line and by software requests.
// - A peripheral-to-memory tail shorter than a burst may be served by burst or single requests.
// - While the remaining count is at least the burst size, single requests are ignored.
// - Once the remaining count is below the burst size, single requests move one beat each.
// - Memory-to-memory runs without any request and the channel stops when its count is done.
// - Peripheral-to-peripheral needs source and destination burst lines or a software request.
// - Channel 0 may start between channel 1 bursts; channel 1 never starts while channel 0 runs.
// - Peripheral-to-peripheral is only accepted when one end is a buffer or timer register.
// - The sixteen request lines are shared by both channels and carry burst requests only.
// - A software burst request starts a transfer like a hardware request.
// - A memory-to-memory channel ignores the hardware request lines.
package dmatr_pkg;
  localparam int NUM_CH = 2;
  localparam int NUM_REQ = 16;
  localparam int CNT_W = 12;
  localparam int BEAT_W = 9;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] XT_M2P = 2'h0;
  localparam logic [1:0] XT_P2M = 2'h1;
  localparam logic [1:0] XT_M2M = 2'h2;
  localparam logic [1:0] XT_P2P = 2'h3;
  localparam logic [BEAT_W-1:0] BEATS_ONE = 9'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;

  typedef enum logic [1:0] {ENG_IDLE, ENG_REQ, ENG_RUN} dmatr_eng_t;

  typedef struct packed {
    dmatr_eng_t eng;
    logic own;
    logic [BEAT_W-1:0] beats;
    logic [NUM_CH-1:0] act;
    logic [NUM_CH-1:0][CNT_W-1:0] rem;
    logic [NUM_CH-1:0] sb;
    logic [NUM_CH-1:0] ss;
    logic [NUM_CH-1:0] tc;
    logic [NUM_CH-1:0] er;
  } dmatr_state_t;

  localparam dmatr_state_t STATE_RESET = '{eng: ENG_IDLE, own: 1'b0, beats: '0, act: '0,
                                           rem: '0, sb: '0, ss: '0, tc: '0, er: '0};

  typedef struct packed {
    logic [NUM_REQ-1:0] s1;
    logic [NUM_REQ-1:0] s2;
  } dmatr_sync_t;

  // Burst size code 0 is one beat, codes 1..7 are 4..256 beats
  function automatic logic [BEAT_W-1:0] dmatr_burst_len(input logic [2:0] code);
    logic [BEAT_W-1:0] len;
    // Shift amount is widened so that code 7 does not wrap back to a shift of 0
    len = (code == 3'h0) ? BEATS_ONE : BEAT_W'(BEATS_ONE << ({1'b0, code} + 4'h1));
    return len;
  endfunction : dmatr_burst_len
endpackage : dmatr_pkg

// *** dmatr_req_if.sv ***
`timescale 1ns/10ps
interface dmatr_req_if;
  logic [dmatr_pkg::NUM_REQ-1:0] burst_req;
  modport src (output burst_req);
  modport dst (input burst_req);
endinterface : dmatr_req_if

// *** dmatr_req_sync.sv ***
`timescale 1ns/10ps
module dmatr_req_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [dmatr_pkg::NUM_REQ-1:0] req_line,
  dmatr_req_if.src req
);
  import dmatr_pkg::*;

  dmatr_sync_t state_reg;
  dmatr_sync_t state_next;

  always_comb
  begin
    state_next.s1 = req_line;
    state_next.s2 = state_reg.s1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  // Each line is a burst request shared by both channels
  assign req.burst_req = state_reg.s2;

  AST_SYNC_LATENCY: assert property (@(posedge clk) disable iff (!reset_n)
    ##2 req.burst_req == $past(req_line, 2))
    else $error("request line not delivered after two stages");
endmodule : dmatr_req_sync

// *** test_dma_transfer_type_request_handling.sv ***
`timescale 1ns/10ps
module test_dma_transfer_type_request_handling;
  import dmatr_pkg::*;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic [NUM_REQ-1:0] rq = '0;
  logic [NUM_CH-1:0] st = '0, ok = '0, sb = '0, ss = '0;
  logic [NUM_CH-1:0][1:0] xt = '0;
  logic [NUM_CH-1:0][2:0] bs = '0;
  logic [NUM_CH-1:0][CNT_W-1:0] cn = '0;
  logic [NUM_CH-1:0][3:0] sl = '0, dl = '0;
  logic xv, xc, xr, xd, xe;
  logic [BEAT_W-1:0] xb;
  logic [NUM_CH-1:0] act, tci, eri;
  logic [1:0] wt = 2'h2;
  logic inj = 1'h0;
  logic [9:0] lq[$];
  int tc[2], er[2];
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  dmatr_ctrl i_dut (.clk(clk), .reset_n(reset_n), .dma_req_line(rq), .ch_start(st),
    .ch_xtype(xt), .ch_bsize(bs), .ch_count(cn), .ch_src_line(sl), .ch_dst_line(dl),
    .ch_p2p_ok(ok), .soft_burst_req(sb), .soft_single_req(ss), .xfer_valid(xv),
    .xfer_ch(xc), .xfer_beats(xb), .xfer_ready(xr), .xfer_done(xd), .xfer_err(xe),
    .ch_active(act), .xfer_complete_irq(tci), .xfer_error_irq(eri));
  dmatr_bus_model i_bus (.clk(clk), .reset_n(reset_n), .xfer_valid(xv), .wait_cyc(wt),
    .inject_err(inj), .xfer_ready(xr), .xfer_done(xd), .xfer_err(xe));

  // Logs accepted commands as {channel, beats} and counts interrupt pulses
  always @(posedge clk)
  begin
    cyc++;
    if (xv === 1'h1 && xr === 1'h1)
      lq.push_back({xc, xb});
    for (int c = 0; c < 2; c++)
    begin
      tc[c] += int'(tci[c] === 1'h1);
      er[c] += int'(eri[c] === 1'h1);
    end
    if (cyc == 5000)
    begin
      fails++;
      conclude();
    end
  end

  task automatic check(input string w, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", w, e, s);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  task automatic cfg(input int c, input logic [1:0] t, input logic [2:0] b,
                     input logic [11:0] n, input logic [3:0] s, input logic [3:0] d);
    xt[c] = t;
    bs[c] = b;
    cn[c] = n;
    sl[c] = s;
    dl[c] = d;
  endtask : cfg

  task automatic go(input logic [1:0] m);
    @(negedge clk);
    lq.delete();
    tc = '{0, 0};
    er = '{0, 0};
    st = m;
    @(negedge clk);
    st = '0;
  endtask : go

  task automatic pulse(ref logic [NUM_CH-1:0] sig, input int c);
    @(negedge clk);
    sig[c] = 1'h1;
    @(negedge clk);
    sig[c] = 1'h0;
  endtask : pulse

  task automatic wait_log(input int n);
    for (int i = 0; i < 300 && lq.size() < n; i++)
      @(negedge clk);
  endtask : wait_log

  task automatic wait_idle();
    for (int i = 0; i < 300 && act !== 2'h0; i++)
      @(negedge clk);
    idle(2);
  endtask : wait_idle

  task automatic log_is(input logic [9:0] e[$]);
    check("cmds", 16'(lq.size()), 16'(e.size()));
    foreach (e[i])
      check("cmd", 16'(lq[i]), 16'(e[i]));
  endtask : log_is

  task automatic t_m2m_prio();
    cfg(0, XT_M2M, 3'h1, 12'h004, 4'h0, 4'h0);
    cfg(1, XT_M2M, 3'h1, 12'h008, 4'h0, 4'h0);
    go(2'h3);
    wait_log(3);
    wait_idle();
    log_is('{10'h004, 10'h204, 10'h204});
    check("tc", 16'(tc[0] * 2 + tc[1]), 16'h3);
    $display("test m2m_prio done");
  endtask : t_m2m_prio

  task automatic t_p2m_tail();
    cfg(0, XT_P2M, 3'h1, 12'h006, 4'h3, 4'h0);
    go(2'h1);
    pulse(ss, 0);
    idle(12);
    check("early", 16'(lq.size()), 16'h0);
    rq[3] = 1'h1;
    wait_log(1);
    rq[3] = 1'h0;
    pulse(ss, 0);
    wait_log(2);
    rq[3] = 1'h1;
    wait_log(3);
    rq[3] = 1'h0;
    wait_idle();
    log_is('{10'h004, 10'h001, 10'h001});
    check("tc", 16'(tc[0]), 16'h1);
    $display("test p2m_tail done");
  endtask : t_p2m_tail

  task automatic t_m2p_p2p();
    wt = 2'h0;
    cfg(1, XT_M2P, 3'h0, 12'h002, 4'h7, 4'h5);
    go(2'h2);
    rq[7] = 1'h1;
    idle(10);
    check("src", 16'(lq.size()), 16'h0);
    rq[5] = 1'h1;
    wait_log(2);
    wait_idle();
    rq = '0;
    log_is('{10'h201, 10'h201});
    cfg(1, XT_P2P, 3'h1, 12'h004, 4'h2, 4'h4);
    go(2'h2);
    idle(4);
    check("rej", 16'({act, 8'(er[1])}), 16'h1);
    ok[1] = 1'h1;
    go(2'h2);
    rq[2] = 1'h1;
    idle(10);
    check("p2p", 16'(lq.size()), 16'h0);
    rq[4] = 1'h1;
    wait_log(1);
    wait_idle();
    rq = '0;
    log_is('{10'h204});
    $display("test m2p_p2p done");
  endtask : t_m2p_p2p

  task automatic t_soft_err();
    wt = 2'h3;
    cfg(0, XT_M2P, 3'h1, 12'h008, 4'h0, 4'h9);
    go(2'h1);
    pulse(sb, 0);
    wait_log(1);
    inj = 1'h1;
    wait_idle();
    inj = 1'h0;
    log_is('{10'h004});
    check("err", 16'({8'(er[0]), 8'(tc[0])}), 16'h0100);
    $display("test soft_err done");
  endtask : t_soft_err

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  initial
  begin
    idle(4);
    reset_n = 1'h1;
    idle(2);
    t_m2m_prio();
    t_p2m_tail();
    t_m2p_p2p();
    t_soft_err();
    conclude();
  end
endmodule : test_dma_transfer_type_request_handling
